// ### include/isp_jtag_pkg.sv
package isp_jtag_pkg;
  // clock rate and stage times
  localparam int CLK_MHZ = 200;
  localparam int ENTER_MS = 1;
  localparam int EXIT_MS = 1;
  localparam int ERASE_MS = 100;
  localparam int PROG_US = 10;
  localparam int READ_US = 1;
  localparam int ENTER_CYC = ENTER_MS * 1000 * CLK_MHZ;
  localparam int EXIT_CYC = EXIT_MS * 1000 * CLK_MHZ;
  localparam int ERASE_CYC = ERASE_MS * 1000 * CLK_MHZ;
  localparam int PROG_CYC = PROG_US * CLK_MHZ;
  localparam int READ_CYC = READ_US * CLK_MHZ;
  // register lengths
  localparam int IR_LEN = 10;
  localparam int ID_LEN = 32;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int BSR_LEN_DEF = 288;
  localparam logic [1:0] IR_CAP_LSB = 2'h1;
  // identification fields, values arbitrary
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'hA5C3;
  localparam logic [10:0] ID_MAKER = 11'h2B4;
  localparam logic ID_LSB = 1'b1;
  // instruction codes
  localparam logic [9:0] IR_EXTEST = 10'h000;
  localparam logic [9:0] IR_SAMPLE = 10'h055;
  localparam logic [9:0] IR_IDCODE = 10'h059;
  localparam logic [9:0] IR_BYPASS = 10'h3FF;
  localparam logic [9:0] IR_ADDR = 10'h203;
  localparam logic [9:0] IR_DATA = 10'h204;
  localparam logic [9:0] IR_ENTER = 10'h2C0;
  localparam logic [9:0] IR_EXIT = 10'h2C1;
  localparam logic [9:0] IR_ERASE = 10'h2C2;
  localparam logic [9:0] IR_PROG = 10'h2C3;
  localparam logic [9:0] IR_READ = 10'h2C4;
  localparam logic [9:0] IR_SECURE = 10'h2C5;
  typedef enum logic [2:0] {
    CMD_ENTER = 3'h0, CMD_EXIT = 3'h1, CMD_ERASE = 3'h2,
    CMD_PROG = 3'h3, CMD_READ = 3'h4, CMD_SECURE = 3'h5
  } cmd_t;
  typedef struct packed {
    cmd_t cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmd_word_t;
  localparam int CMD_W = $bits(cmd_word_t);
endpackage

// ### src/isp_jtag_port.sv
`timescale 1ns/1ps
// small same-clock fifo between command crossing and pulse engine
module isp_cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_t;
  fifo_t st_ff, nxt_st;
  logic push, pop;

  // handshakes on both sides
  assign in_ready_o = st_ff.cnt != (AW+1)'(DEPTH);
  assign out_valid_o = st_ff.cnt != '0;
  assign out_data_o = st_ff.mem[st_ff.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // pointer and count update
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data_i;
      nxt_st.wp = AW'((st_ff.wp + 1'b1) % DEPTH);
    end
    if (pop) begin
      nxt_st.rp = AW'((st_ff.rp + 1'b1) % DEPTH);
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// Overview of operation
// - serial shift in on tdi, out on tdo
// - enter takes pins to programming, 1 ms
// - bulk erase: one 100 ms pulse
// - per address: shift address, data, program pulse
// - per address: read pulse, shift out contents
// - exit returns pins to user, 1 ms
// - instruction register is 10 bits
// - boundary-scan length set per variant
// - no scan cells: extest/sample shift a zero-capture register BSR_LEN bits long
// - idcode: version, part, maker, lsb one
// - security bit blocks readback until erase
module isp_jtag_port #(
  parameter int BSR_LEN = isp_jtag_pkg::BSR_LEN_DEF,
  parameter int DEPTH = 64,
  parameter int ENTER_CYC = isp_jtag_pkg::ENTER_CYC,
  parameter int EXIT_CYC = isp_jtag_pkg::EXIT_CYC,
  parameter int ERASE_CYC = isp_jtag_pkg::ERASE_CYC,
  parameter int PROG_CYC = isp_jtag_pkg::PROG_CYC,
  parameter int READ_CYC = isp_jtag_pkg::READ_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic in_system_programming_o,
  output logic busy_o
);
  import isp_jtag_pkg::*;
  localparam int DRW = (BSR_LEN > ID_LEN) ? BSR_LEN : ID_LEN;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, SEL_DR = 4'h3, CAP_DR = 4'h2,
    SH_DR = 4'h6, EX1_DR = 4'h7, PAU_DR = 4'h5, EX2_DR = 4'h4,
    UPD_DR = 4'hC, SEL_IR = 4'hD, CAP_IR = 4'hF, SH_IR = 4'hE,
    EX1_IR = 4'hA, PAU_IR = 4'hB, EX2_IR = 4'h9, UPD_IR = 4'h8
  } tap_t;
  typedef enum logic [1:0] {E_IDLE = 2'h0, E_RUN = 2'h1} eng_t;

  typedef struct packed {
    tap_t tap;
    logic [IR_LEN-1:0] ir_sh;
    logic [IR_LEN-1:0] ir;
    logic [DRW-1:0] dr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] rd_shadow;
    cmd_word_t req_word;
    logic req_tgl;
    logic ack_s1, ack_s2;
    logic done_s1, done_s2, done_s3;
    logic busy_s1, busy_s2;
    logic drop;
    logic tdo, tdo_oe;
  } tck_st_t;

  typedef struct packed {
    logic req_s1, req_s2;
    logic ack_tgl;
    eng_t eng;
    logic [31:0] timer;
    cmd_word_t cur;
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic secure;
    logic mode;
    logic [DATA_W-1:0] rd_word;
    logic done_tgl;
    logic busy;
  } m_st_t;

  tck_st_t t_ff, nxt_t;
  m_st_t m_ff, nxt_m;
  logic f_ready, f_valid, f_pop;
  cmd_word_t f_data;

  // next tap state from tms
  function automatic tap_t tap_next(input tap_t s, input logic tms);
    unique case (s)
      TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_next = tms ? SEL_DR : TAP_IDLE;
      SEL_DR: tap_next = tms ? SEL_IR : CAP_DR;
      CAP_DR: tap_next = tms ? EX1_DR : SH_DR;
      SH_DR: tap_next = tms ? EX1_DR : SH_DR;
      EX1_DR: tap_next = tms ? UPD_DR : PAU_DR;
      PAU_DR: tap_next = tms ? EX2_DR : PAU_DR;
      EX2_DR: tap_next = tms ? UPD_DR : SH_DR;
      UPD_DR: tap_next = tms ? SEL_DR : TAP_IDLE;
      SEL_IR: tap_next = tms ? TAP_RESET : CAP_IR;
      CAP_IR: tap_next = tms ? EX1_IR : SH_IR;
      SH_IR: tap_next = tms ? EX1_IR : SH_IR;
      EX1_IR: tap_next = tms ? UPD_IR : PAU_IR;
      PAU_IR: tap_next = tms ? EX2_IR : PAU_IR;
      EX2_IR: tap_next = tms ? UPD_IR : SH_IR;
      UPD_IR: tap_next = tms ? SEL_DR : TAP_IDLE;
    endcase
  endfunction

  // scan length selected by the instruction
  function automatic int dr_len(input logic [IR_LEN-1:0] ir);
    if (ir == IR_IDCODE) begin
      dr_len = ID_LEN;
    end else if (ir == IR_EXTEST || ir == IR_SAMPLE) begin
      dr_len = (BSR_LEN > 1) ? BSR_LEN : 1;
    end else if (ir == IR_ADDR) begin
      dr_len = ADDR_W;
    end else if (ir == IR_DATA) begin
      dr_len = DATA_W;
    end else begin
      dr_len = 1;
    end
  endfunction

  // instruction to engine command, bit 3 marks a command
  function automatic logic [3:0] ir_cmd(input logic [IR_LEN-1:0] ir);
    unique case (ir)
      IR_ENTER: ir_cmd = {1'b1, CMD_ENTER};
      IR_EXIT: ir_cmd = {1'b1, CMD_EXIT};
      IR_ERASE: ir_cmd = {1'b1, CMD_ERASE};
      IR_PROG: ir_cmd = {1'b1, CMD_PROG};
      IR_READ: ir_cmd = {1'b1, CMD_READ};
      IR_SECURE: ir_cmd = {1'b1, CMD_SECURE};
      default: ir_cmd = 4'h0;
    endcase
  endfunction

  // pulse length of each command
  function automatic logic [31:0] cmd_cyc(input cmd_t c);
    unique case (c)
      CMD_ENTER: cmd_cyc = 32'(ENTER_CYC);
      CMD_EXIT: cmd_cyc = 32'(EXIT_CYC);
      CMD_ERASE: cmd_cyc = 32'(ERASE_CYC);
      CMD_PROG: cmd_cyc = 32'(PROG_CYC);
      CMD_READ: cmd_cyc = 32'(READ_CYC);
      CMD_SECURE: cmd_cyc = 32'(PROG_CYC);
      default: cmd_cyc = 32'h1;
    endcase
  endfunction

  // test clock side: tap, scan registers, command issue
  always_comb begin
    int len;
    logic [3:0] c;
    logic pend;
    len = dr_len(t_ff.ir);
    c = ir_cmd(t_ff.ir_sh);
    pend = t_ff.req_tgl != t_ff.ack_s2;
    nxt_t = t_ff;
    nxt_t.ack_s1 = m_ff.ack_tgl;
    nxt_t.ack_s2 = t_ff.ack_s1;
    nxt_t.done_s1 = m_ff.done_tgl;
    nxt_t.done_s2 = t_ff.done_s1;
    nxt_t.done_s3 = t_ff.done_s2;
    nxt_t.busy_s1 = m_ff.busy;
    nxt_t.busy_s2 = t_ff.busy_s1;
    if (t_ff.done_s2 != t_ff.done_s3) begin
      nxt_t.rd_shadow = m_ff.rd_word;
    end
    nxt_t.tap = tap_next(t_ff.tap, tms_i);
    unique case (t_ff.tap)
      TAP_RESET: begin
        nxt_t.ir = IR_IDCODE;
        nxt_t.drop = 1'b0;
      end
      CAP_IR: begin
        nxt_t.ir_sh = {6'h0, t_ff.drop, pend | t_ff.busy_s2, IR_CAP_LSB};
      end
      SH_IR: begin
        nxt_t.ir_sh = {tdi_i, t_ff.ir_sh[IR_LEN-1:1]};
      end
      UPD_IR: begin
        nxt_t.ir = t_ff.ir_sh;
        if (c[3] && pend) begin
          nxt_t.drop = 1'b1;
        end else if (c[3]) begin
          nxt_t.req_word = {cmd_t'(c[2:0]), t_ff.addr, t_ff.data};
          nxt_t.req_tgl = ~t_ff.req_tgl;
        end
      end
      CAP_DR: begin
        nxt_t.dr = '0;
        if (t_ff.ir == IR_IDCODE) begin
          nxt_t.dr[ID_LEN-1:0] = {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};
        end else if (t_ff.ir == IR_ADDR) begin
          nxt_t.dr[ADDR_W-1:0] = t_ff.addr;
        end else if (t_ff.ir == IR_DATA) begin
          nxt_t.dr[DATA_W-1:0] = t_ff.rd_shadow;
        end
      end
      SH_DR: begin
        nxt_t.dr = t_ff.dr >> 1;
        nxt_t.dr[len-1] = tdi_i;
      end
      UPD_DR: begin
        if (t_ff.ir == IR_ADDR) begin
          nxt_t.addr = t_ff.dr[ADDR_W-1:0];
        end
        if (t_ff.ir == IR_DATA) begin
          nxt_t.data = t_ff.dr[DATA_W-1:0];
        end
      end
      default: ;
    endcase
    // tdo shows the bit that the next rising edge shifts out
    nxt_t.tdo_oe = nxt_t.tap == SH_IR || nxt_t.tap == SH_DR;
    nxt_t.tdo = (nxt_t.tap == SH_IR) ? nxt_t.ir_sh[0] : nxt_t.dr[0];
  end

  always_ff @(posedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      t_ff <= '{tap: TAP_RESET, ir: IR_IDCODE, default: '0};
    end else begin
      t_ff <= nxt_t;
    end
  end

  // commands wait here while the engine runs long pulses
  isp_cmd_fifo #(.WIDTH(CMD_W), .DEPTH(8)) u_fifo (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(m_ff.req_s2 != m_ff.ack_tgl),
    .in_ready_o(f_ready),
    .in_data_i(t_ff.req_word),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_data)
  );
  assign f_pop = m_ff.eng == E_IDLE;

  // main clock side: crossing, timed pulses, cell array
  always_comb begin
    nxt_m = m_ff;
    nxt_m.req_s1 = t_ff.req_tgl;
    nxt_m.req_s2 = m_ff.req_s1;
    if (m_ff.req_s2 != m_ff.ack_tgl && f_ready) begin
      nxt_m.ack_tgl = m_ff.req_s2;
    end
    unique case (m_ff.eng)
      E_IDLE: begin
        // outside programming mode only enter is honoured
        if (f_valid && (f_data.cmd == CMD_ENTER || m_ff.mode)) begin
          nxt_m.cur = f_data;
          nxt_m.timer = cmd_cyc(f_data.cmd) - 32'h1;
          nxt_m.eng = E_RUN;
          if (f_data.cmd == CMD_ENTER) begin
            nxt_m.mode = 1'b1;
          end
        end
      end
      E_RUN: begin
        if (m_ff.timer != '0) begin
          nxt_m.timer = m_ff.timer - 32'h1;
        end else begin
          nxt_m.eng = E_IDLE;
          unique case (m_ff.cur.cmd)
            CMD_EXIT: nxt_m.mode = 1'b0;
            CMD_ERASE: begin
              nxt_m.mem = '0;
              nxt_m.secure = 1'b0;
            end
            CMD_PROG: nxt_m.mem[m_ff.cur.addr] = m_ff.cur.data;
            CMD_SECURE: nxt_m.secure = 1'b1;
            CMD_READ: begin
              nxt_m.rd_word = m_ff.secure ? '0 : m_ff.mem[m_ff.cur.addr];
              nxt_m.done_tgl = ~m_ff.done_tgl;
            end
            default: ;
          endcase
        end
      end
      default: nxt_m.eng = E_IDLE;
    endcase
    nxt_m.busy = nxt_m.eng != E_IDLE || f_valid;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      m_ff <= '{eng: E_IDLE, default: '0};
    end else begin
      m_ff <= nxt_m;
    end
  end

  assign tdo_o = t_ff.tdo;
  assign tdo_oe_o = t_ff.tdo_oe;
  assign in_system_programming_o = m_ff.mode;
  assign busy_o = m_ff.busy;
endmodule

// ### dv/isp_jtag_assertions.sv
`timescale 1ns/1ps
module isp_jtag_assertions #(
  parameter int ENTER_CYC = 20,
  parameter int EXIT_CYC = 20
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic in_system_programming_o,
  input wire logic busy_o
);
  int isp_cnt_ff;
  // cycles spent in programming mode
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      isp_cnt_ff <= 0;
    else if (!in_system_programming_o)
      isp_cnt_ff <= 0;
    else
      isp_cnt_ff <= isp_cnt_ff + 1;
  end
  // shift enable follows the tap graph
  chk_oe_enter_low: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    $rose(tdo_oe_o) |-> !$past(tms_i)) else $error("shift entered with tms high");
  chk_oe_leave_tms: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    tms_i |=> !tdo_oe_o) else $error("shift kept with tms high");
  chk_oe_hold_low: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    tdo_oe_o && !tms_i |=> tdo_oe_o) else $error("shift left with tms low");
  chk_oe_reset_off: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    !$past(rst_n_i) |-> !tdo_oe_o) else $error("tdo enabled after reset");
  // idle after reset, pin mode changes around enter and exit
  chk_idle_after_rst: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !$past(rst_n_i) |-> !busy_o && !in_system_programming_o)
    else $error("not idle after reset");
  chk_enter_busy_run: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(in_system_programming_o) |-> busy_o [*8])
    else $error("enter stage not busy");
  chk_exit_busy_fall: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(in_system_programming_o) |-> $past(busy_o))
    else $error("user mode without exit stage");
  chk_isp_span_min: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(in_system_programming_o) |-> isp_cnt_ff >= ENTER_CYC + EXIT_CYC - 2)
    else $error("programming mode too short");
endmodule

bind isp_jtag_port isp_jtag_assertions #(
  .ENTER_CYC(ENTER_CYC), .EXIT_CYC(EXIT_CYC)) chk_u (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .tck_i(tck_i), .tms_i(tms_i),
  .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
  .in_system_programming_o(in_system_programming_o), .busy_o(busy_o));

// ### dv/jtag_prog_model.sv
`timescale 1ns/1ps
// programmer side of the port; tck stands still outside frames
module jtag_prog_model
  import isp_jtag_pkg::*;
(
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  // idle levels at time zero
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // one 48 ns tck cycle; tdo taken at the rising edge
  task automatic pulse(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #23;
    tdo = tdo_i;
    tck_o = 1'b1;
    #24;
    tck_o = 1'b0;
    #1;
  endtask
  // from select: capture, shift n bits lsb first, update, idle
  task automatic scan(input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic b;
    dout = '0;
    pulse(1'b0, 1'b0, b);
    pulse(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], b);
      dout[i] = b;
    end
    // idle tdi shows the inverse of the last bit, never a stale value
    pulse(1'b1, ~din[n-1], b);
    pulse(1'b0, ~din[n-1], b);
  endtask
  task automatic dr(input int n, input logic [31:0] din,
                    output logic [31:0] dout);
    logic b;
    pulse(1'b1, 1'b0, b);
    scan(n, din, dout);
  endtask
  task automatic ir(input logic [9:0] code, output logic [9:0] cap);
    logic b;
    logic [31:0] d;
    pulse(1'b1, 1'b0, b);
    pulse(1'b1, 1'b0, b);
    scan(IR_LEN, {22'h0, code}, d);
    cap = d[9:0];
  endtask
  // five tms high reach reset, then park in idle
  task automatic tap_reset();
    logic b;
    repeat (5) pulse(1'b1, 1'b0, b);
    pulse(1'b0, 1'b0, b);
  endtask
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import isp_jtag_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, isp, busy;
  int num_errors = 0;
  int num_checks = 0;
  always #2.5 mclk = ~mclk;
  jtag_prog_model prog_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .tdo_i(tdo));
  // short stage counts, no boundary scan cells; read pulse at its default
  isp_jtag_port #(.BSR_LEN(1), .ENTER_CYC(20), .EXIT_CYC(20),
    .ERASE_CYC(50), .PROG_CYC(5)) dut_u (.mclk_i(mclk),
    .rst_n_i(rst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .in_system_programming_o(isp), .busy_o(busy));
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  // load a command, then poll the busy status bit
  task automatic issue(input logic [9:0] code);
    logic [9:0] cap;
    prog_u.ir(code, cap);
    for (int i = 0; i < 100; i++) begin
      prog_u.ir(IR_BYPASS, cap);
      if (cap[2] === 1'b0)
        return;
    end
    check("idle wait", 32'h0, 32'h1);
    conclude();
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [31:0] o;
    prog_u.ir(IR_ADDR, o[9:0]);
    prog_u.dr(ADDR_W, {26'h0, a}, o);
    prog_u.ir(IR_DATA, o[9:0]);
    prog_u.dr(DATA_W, {16'h0, d}, o);
    issue(IR_PROG);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    logic [31:0] o;
    prog_u.ir(IR_ADDR, o[9:0]);
    prog_u.dr(ADDR_W, {26'h0, a}, o);
    issue(IR_READ);
    prog_u.ir(IR_DATA, o[9:0]);
    prog_u.dr(DATA_W, 32'h0, o);
    check("read word", {16'h0, e}, o);
  endtask
  // stage two: identity read back, abort on mismatch
  task automatic id_check();
    logic [31:0] o;
    prog_u.ir(IR_IDCODE, o[9:0]);
    prog_u.dr(ID_LEN, 32'h0, o);
    check("stage id", {ID_VERSION, ID_PART, ID_MAKER, 1'b1}, o);
    if (o !== {ID_VERSION, ID_PART, ID_MAKER, 1'b1})
      conclude();
  endtask
  // identity after reset and through a 10 bit instruction
  task automatic t_id();
    logic [31:0] o;
    logic [9:0] cap;
    prog_u.dr(ID_LEN, 32'h0, o);
    check("idcode", {ID_VERSION, ID_PART, ID_MAKER, 1'b1}, o);
    prog_u.ir(IR_IDCODE, cap);
    check("ir capture", 32'h1, {22'h0, cap});
    prog_u.dr(ID_LEN, 32'h0, o);
    check("idcode again", {ID_VERSION, ID_PART, ID_MAKER, 1'b1}, o);
    $display("t_id done");
  endtask
  // scan instructions fall back to the one bit bypass
  task automatic t_bypass();
    logic [9:0] codes [3] = '{IR_EXTEST, IR_SAMPLE, IR_BYPASS};
    logic [31:0] o;
    foreach (codes[i]) begin
      prog_u.ir(codes[i], o[9:0]);
      prog_u.dr(8, 32'hB5, o);
      check("bypass path", 32'h6A, {24'h0, o[7:0]});
    end
    $display("t_bypass done");
  endtask
  // full sequence, security, then verify-only and reprogram
  task automatic t_program();
    issue(IR_ERASE);
    check("ignored outside", 32'h0, {31'h0, isp});
    issue(IR_ENTER);
    check("enter mode", 32'h1, {31'h0, isp});
    id_check();
    issue(IR_ERASE);
    wr(6'h00, 16'h1234);
    wr(6'h3F, 16'hEDCB);
    rd(6'h00, 16'h1234);
    rd(6'h3F, 16'hEDCB);
    issue(IR_SECURE);
    rd(6'h3F, 16'h0000);
    issue(IR_EXIT);
    check("exit mode", 32'h0, {31'h0, isp});
    issue(IR_ENTER);
    id_check();
    rd(6'h00, 16'h0000);
    issue(IR_ERASE);
    wr(6'h3F, 16'h0F0F);
    rd(6'h3F, 16'h0F0F);
    issue(IR_EXIT);
    check("exit again", 32'h0, {31'h0, isp});
    $display("t_program done");
  endtask
  // reset with tck moving, then the tests
  initial begin
    logic b;
    fork
      repeat (2) prog_u.pulse(1'b1, 1'b0, b);
      repeat (20) @(posedge mclk);
    join
    #1 rst_n = 1'b1;
    prog_u.tap_reset();
    t_id();
    t_bypass();
    t_program();
    conclude();
  end
endmodule
